// ==== bench/pfsm_pin_mux_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pfsm_defines.vh"
module pfsm_pin_mux_asserts #(
    parameter [1:0] VARIANT = 2'h3
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pin functions
    input wire logic [31:0] port_a_func_r,
    input wire logic [31:0] port_b_func_r,
    input wire logic [15:0] port_e_func_r,
    input wire logic compact_timer1_clock_in_en_r,
    input wire logic external_interrupt_one_en_r,
    input wire logic [1:0] standard_timer_capture_in_en_r,
    input wire logic [5:0] porte_bit3_touch_r
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    a_reset_clear: assert property (
        $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && s_axi_awready && s_axi_arready
            && port_a_func_r == 32'h0 && port_b_func_r == 32'h0)
        else $error("state not cleared by reset");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en
            |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
        else $error("read data late");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_aw_busy: assert property (
        s_axi_awvalid && s_axi_awready && clk_en |=> !s_axi_awready)
        else $error("write address taken twice");
    a_ar_busy: assert property (
        s_axi_arvalid && s_axi_arready && clk_en |=> !s_axi_arready)
        else $error("read address taken twice");
    a_rdata_narrow: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
            && (s_axi_rresp != `PFSM_RESP_SLVERR || s_axi_rdata == 32'h0))
        else $error("read data upper bits set");
    a_ct1_v1_only: assert property (
        (VARIANT != `PFSM_VAR_V1) |-> !compact_timer1_clock_in_en_r)
        else $error("timer clock input outside variant one");
    a_pe3_touch: assert property (
        porte_bit3_touch_r != 6'h0 |-> port_e_func_r[15:12] == `PFSM_FN_TOUCH
            && porte_bit3_touch_r == ((VARIANT == `PFSM_VAR_V1) ? 6'h0C : 6'h18))
        else $error("touch number inconsistent");
    a_pe3_capture: assert property (
        standard_timer_capture_in_en_r[1] |-> port_e_func_r[15:12] == `PFSM_FN_GPIO)
        else $error("capture input on non io pin");
    a_pb7_int_io: assert property (
        external_interrupt_one_en_r |-> port_b_func_r[31:28] == `PFSM_FN_GPIO)
        else $error("interrupt input on non io pin");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read_err: cover property (s_axi_rvalid && s_axi_rresp == `PFSM_RESP_SLVERR);
    c_touch: cover property (porte_bit3_touch_r != 6'h0);
endmodule
bind pfsm_pin_mux pfsm_pin_mux_asserts #(.VARIANT(VARIANT)) pfsm_pin_mux_asserts_i (
    .aclk, .aresetn, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_a_func_r, .port_b_func_r, .port_e_func_r, .compact_timer1_clock_in_en_r,
    .external_interrupt_one_en_r, .standard_timer_capture_in_en_r, .porte_bit3_touch_r);
`default_nettype wire

// ==== bench/tb_pfsm_pin_mux.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pfsm_defines.vh"
module tb_pfsm_pin_mux;
    logic aclk = 1'b0;
    logic aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic compact_timer1_clock_in_en_r, periodic_timer_clock_in_en_r;
    logic standard_timer_clock_in_en_r, external_interrupt_one_en_r;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, port_a_func_r, port_b_func_r;
    logic [31:0] port_c_func_r, port_d_func_r;
    logic [15:0] port_e_func_r;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [1:0] periodic_timer_capture_in_en_r, standard_timer_capture_in_en_r;
    logic [5:0] porte_bit3_touch_r, porte_bit2_touch_r, porte_bit1_touch_r;
    logic [7:0] sh [9];
    int errors = 0;
    int num_checks = 0;
    int tk;
    // function code per code value, nibble n for code n, by register and field
    localparam logic [15:0] FN_TAB [36] = '{
        16'h0050, 16'h0030, 16'h0010, 16'h0210, 16'h0250, 16'h0040, 16'h0000, 16'h0000,
        16'hA980, 16'hA070, 16'hA360, 16'hA060, 16'hAB40, 16'hAB00, 16'hAB00, 16'hAB00,
        16'h0B00, 16'h0B00, 16'h0B00, 16'h0B00, 16'h0B00, 16'h0B00, 16'h0B00, 16'h0B00,
        16'h0B00, 16'h0B00, 16'h0B00, 16'h0B00, 16'h0B00, 16'h0B00, 16'h0B00, 16'h0B00,
        16'h0000, 16'h0B00, 16'h0B30, 16'h0B40};

    pfsm_pin_mux pfsm_pin_mux_i (
        .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_func_r,
        .port_b_func_r, .port_c_func_r, .port_d_func_r, .port_e_func_r,
        .compact_timer1_clock_in_en_r, .periodic_timer_capture_in_en_r,
        .periodic_timer_clock_in_en_r, .standard_timer_clock_in_en_r,
        .external_interrupt_one_en_r, .standard_timer_capture_in_en_r,
        .porte_bit3_touch_r, .porte_bit2_touch_r, .porte_bit1_touch_r);

    always #10 aclk = ~aclk;
    ////////////////////////////////////////
    task automatic summarize();
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
            input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                chk("rdata", exp, s_axi_rdata);
                chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // compares every pin output except port e pin 0 against the shadow copy of the fields
    task automatic check_all();
        logic [143:0] fn;
        logic [1:0] c;
        fn = {port_e_func_r, port_d_func_r, port_c_func_r, port_b_func_r, port_a_func_r};
        tk = 0;
        for (int r = 0; r < 9; r++) begin
            for (int f = 0; f < 4; f++) begin
                if (r == 8 && f == 0) continue;
                c = sh[r][2*f+:2];
                tk += int'(FN_TAB[r*4+f][c*4+:4] == 4'hB);
                chk($sformatf("fn%0d_%0d", r, f), {28'h0, FN_TAB[r*4+f][c*4+:4]},
                    {28'h0, fn[(r/2)*32+(r%2)*16+f*4+:4]});
            end
        end
        chk("ptcap", {30'h0, sh[3][1:0] == 2'h0, sh[2][5:4] == 2'h0},
            {30'h0, periodic_timer_capture_in_en_r});
        chk("clkint", {29'h0, sh[3][7:6] < 2'h2, sh[3][5:4] < 2'h2, sh[3][3:2] < 2'h2},
            {29'h0, external_interrupt_one_en_r, periodic_timer_clock_in_en_r,
            standard_timer_clock_in_en_r});
        chk("stcap", {30'h0, sh[8][7:6] inside {2'h0, 2'h3}, sh[8][5:4] inside {2'h0, 2'h3}},
            {30'h0, standard_timer_capture_in_en_r});
        chk("ct1", 32'h0, {31'h0, compact_timer1_clock_in_en_r});
        chk("touch", {14'h0, (sh[8][7:6] == 2'h2) ? 6'h18 : 6'h00,
            (sh[8][5:4] == 2'h2) ? 6'h17 : 6'h00, (sh[8][3:2] == 2'h2) ? 6'h16 : 6'h00},
            {14'h0, porte_bit3_touch_r, porte_bit2_touch_r,
            porte_bit1_touch_r});
    endtask

    task automatic reset_and_check();
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int r = 0; r < 9; r++) sh[r] = 8'h00;
        @(negedge aclk);
        check_all();
        for (int r = 0; r < 9; r++) rd(8'(r * 4), 32'h0, `PFSM_RESP_OKAY);
    endtask
    ////////////////////////////////////////
    initial begin
        logic [7:0] d;
        clk_en <= 1'b1;
        s_axi_awaddr <= 8'h00;
        s_axi_awvalid <= 1'b0;
        s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'h0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b0;
        s_axi_araddr <= 8'h00;
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        reset_and_check();
        // each field sees every code once, fields differ within a byte
        for (int it = 0; it < 4; it++) begin
            for (int r = 0; r < 9; r++) begin
                for (int f = 0; f < 4; f++) d[2*f+:2] = 2'((it + f + r) % 4);
                wr(8'(r * 4), d, 4'hF, `PFSM_RESP_OKAY);
                sh[r] = d & ((r == 1) ? 8'h0F : 8'hFF);
                @(negedge aclk);
                check_all();
            end
            for (int r = 0; r < 9; r++) rd(8'(r * 4), {24'h0, sh[r]}, `PFSM_RESP_OKAY);
        end
        wr(8'h28, 8'h5A, 4'hF, `PFSM_RESP_SLVERR);
        wr(8'h02, 8'h5A, 4'hF, `PFSM_RESP_SLVERR);
        wr(8'h00, 8'h5A, 4'hE, `PFSM_RESP_OKAY);
        rd(8'h00, {24'h0, sh[0]}, `PFSM_RESP_OKAY);
        rd(8'h28, 32'h0, `PFSM_RESP_SLVERR);
        rd(8'h24, tk, `PFSM_RESP_OKAY);
        @(negedge aclk);
        check_all();
        @(posedge aclk);
        reset_and_check();
        summarize();
    end

    // the tests need well under two thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        errors++;
        summarize();
    end
endmodule
`default_nettype wire

// ==== verilog/pfsm_defines.vh ====
`ifndef PFSM_DEFINES_VH
`define PFSM_DEFINES_VH

// register byte offsets on the bus
`define PFSM_OFF_PA0 8'h00
`define PFSM_OFF_PA1 8'h04
`define PFSM_OFF_PB0 8'h08
`define PFSM_OFF_PB1 8'h0C
`define PFSM_OFF_PC0 8'h10
`define PFSM_OFF_PC1 8'h14
`define PFSM_OFF_PD0 8'h18
`define PFSM_OFF_PD1 8'h1C
`define PFSM_OFF_PE0 8'h20
`define PFSM_OFF_STAT 8'h24

// register reset value
`define PFSM_RST_VAL 8'h00

// selection codes
`define PFSM_SEL_GPIO 2'h0
`define PFSM_SEL_ALT1 2'h1
`define PFSM_SEL_ALT2 2'h2
`define PFSM_SEL_ALT3 2'h3

// function codes driven per pin
`define PFSM_FN_GPIO 4'h0
`define PFSM_FN_SLAVE_SEL 4'h1
`define PFSM_FN_XTAL 4'h2
`define PFSM_FN_TMR_OUT 4'h3
`define PFSM_FN_TMR_OUT_INV 4'h4
`define PFSM_FN_SER_OUT 4'h5
`define PFSM_FN_UART 4'h6
`define PFSM_FN_SER_CLK 4'h7
`define PFSM_FN_SER_IN 4'h8
`define PFSM_FN_VREF 4'h9
`define PFSM_FN_ANALOG 4'hA
`define PFSM_FN_TOUCH 4'hB

// variant codes
`define PFSM_VAR_V1 2'h0
`define PFSM_VAR_V2 2'h1
`define PFSM_VAR_V3 2'h2
`define PFSM_VAR_V4 2'h3

// bus response codes
`define PFSM_RESP_OKAY 2'h0
`define PFSM_RESP_SLVERR 2'h2

`endif

// ==== verilog/pfsm_pin_mux.v ====
// Operation
// [RULE1] port a bit 3: 01 slave select, 10 crystal pin one, else general io
// [RULE2] port a bit 2: 01 slave select, else io; v1 io adds timer1 clock
// [RULE3] port a bit 1: 01 compact timer 0 output, else general io
// [RULE4] port a bit 0: 01 serial data out, else general io
// [RULE5] v1 only, port a bit 7: 01 compact timer 1 output, else io
// [RULE6] port a bit 5: 01 inverted compact timer 0 output, else io
// [RULE7] port a bit 4: 01 serial data out, 10 crystal pin two, else io
// [RULE8] unimplemented bits of second port a register read zero
// [RULE9] port b bit 3: 01 uart receive, 11 analog 3, else io
// [RULE10] port b bit 2: 00 io+capture, 01 uart tx, 10 periodic out, 11 an2
// [RULE11] port b bit 1: 01 serial clock, 11 analog 1, else io
// [RULE12] port b bit 0: 01 serial data in, 10 reference, 11 analog 0
// [RULE13] port b bit 7: 00/01 io+interrupt, 10 touch 4, 11 analog 7
// [RULE14] port b bits 6,5: io+timer clocks, 10 touch 3/2, 11 analog 6/5
// [RULE15] port b bit 4: io+capture, 01 periodic inv, 10 touch 1, 11 an4
// [RULE16] port c pins 0-7: 10 touch 5-12; pins 4-7 only v2-v4
// [RULE17] port d pins 0-3 (v2-v4): 10 touch 13-16, else io
// [RULE18] port d pins 4-7 (v2-v4): 10 touch 17-20, else io
// [RULE19] port e bit 3: 01 std inv out; 10 touch 12/io/24 by variant
// [RULE20] port e bit 2: 01 std timer out; 10 touch 11/io/23 by variant
// [RULE21] port e bit 1: 10 touch 10 v1, 22 v3-v4; v2 unimplemented, reads 0
// [RULE22] fields reset to 00 and drive the mux from stored values
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "pfsm_defines.vh"

module pfsm_pin_mux #(
    parameter [1:0] VARIANT = 2'h3
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // per pin function codes, 4 bits per pin, pin 0 in the low nibble
    output reg [31:0] port_a_func_r,
    output reg [31:0] port_b_func_r,
    output reg [31:0] port_c_func_r,
    output reg [31:0] port_d_func_r,
    output reg [15:0] port_e_func_r,
    // extra input roles while a pin stays general io
    output reg compact_timer1_clock_in_en_r,
    output reg [1:0] periodic_timer_capture_in_en_r,
    output reg periodic_timer_clock_in_en_r,
    output reg standard_timer_clock_in_en_r,
    output reg external_interrupt_one_en_r,
    output reg [1:0] standard_timer_capture_in_en_r,
    // touch key index per pin, zero when not touch
    output reg [5:0] porte_bit3_touch_r,
    output reg [5:0] porte_bit2_touch_r,
    output reg [5:0] porte_bit1_touch_r
);

////////////////////////////////////////////////////////////////////////////////
// selection registers

reg [7:0] port_a_func_sel_0_r;
reg [7:0] port_a_func_sel_1_r;
reg [7:0] port_b_func_sel_0_r;
reg [7:0] port_b_func_sel_1_r;
reg [7:0] port_c_func_sel_0_r;
reg [7:0] port_c_func_sel_1_r;
reg [7:0] port_d_func_sel_0_r;
reg [7:0] port_d_func_sel_1_r;
reg [7:0] port_e_func_sel_0_r;

wire is_v1 = (VARIANT == `PFSM_VAR_V1);
wire is_v2 = (VARIANT == `PFSM_VAR_V2);

// writable masks; unimplemented bits never store, so they read zero
wire [7:0] pa1_mask = is_v1 ? 8'hCF : 8'h0F; // [RULE8]
wire [7:0] pc1_mask = is_v1 ? 8'h00 : 8'hFF; // [RULE16]
wire [7:0] pd_mask = is_v1 ? 8'h00 : 8'hFF; // [RULE17] [RULE18]
wire [7:0] pe0_mask = is_v2 ? 8'hF3 : 8'hFF; // [RULE21]

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave: one write and one read at a time

reg [7:0] wr_addr_r;
reg wr_addr_ok_r;
reg [7:0] wr_data_r;
reg wr_strb0_r;
reg wr_data_ok_r;
reg [5:0] touch_count;
reg [7:0] rd_val;
reg rd_hit;
reg wr_hit;

always @* begin
    rd_hit = 1'b1;
    if (s_axi_araddr == `PFSM_OFF_PA0) begin
        rd_val = port_a_func_sel_0_r;
    end else if (s_axi_araddr == `PFSM_OFF_PA1) begin
        rd_val = port_a_func_sel_1_r;
    end else if (s_axi_araddr == `PFSM_OFF_PB0) begin
        rd_val = port_b_func_sel_0_r;
    end else if (s_axi_araddr == `PFSM_OFF_PB1) begin
        rd_val = port_b_func_sel_1_r;
    end else if (s_axi_araddr == `PFSM_OFF_PC0) begin
        rd_val = port_c_func_sel_0_r;
    end else if (s_axi_araddr == `PFSM_OFF_PC1) begin
        rd_val = port_c_func_sel_1_r;
    end else if (s_axi_araddr == `PFSM_OFF_PD0) begin
        rd_val = port_d_func_sel_0_r;
    end else if (s_axi_araddr == `PFSM_OFF_PD1) begin
        rd_val = port_d_func_sel_1_r;
    end else if (s_axi_araddr == `PFSM_OFF_PE0) begin
        rd_val = port_e_func_sel_0_r;
    end else if (s_axi_araddr == `PFSM_OFF_STAT) begin
        // count of pins currently on a touch key, read-only
        rd_val = {2'h0, touch_count};
    end else begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
    end
end

always @* begin
    wr_hit = (wr_addr_r[1:0] == 2'h0) && (wr_addr_r <= `PFSM_OFF_PE0);
end

wire wr_go = wr_addr_ok_r && wr_data_ok_r && !s_axi_bvalid;

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `PFSM_RESP_OKAY;
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `PFSM_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        wr_addr_r <= 8'h00;
        wr_addr_ok_r <= 1'b0;
        wr_data_r <= 8'h00;
        wr_strb0_r <= 1'b0;
        wr_data_ok_r <= 1'b0;
        port_a_func_sel_0_r <= `PFSM_RST_VAL; // [RULE22]
        port_a_func_sel_1_r <= `PFSM_RST_VAL;
        port_b_func_sel_0_r <= `PFSM_RST_VAL;
        port_b_func_sel_1_r <= `PFSM_RST_VAL;
        port_c_func_sel_0_r <= `PFSM_RST_VAL;
        port_c_func_sel_1_r <= `PFSM_RST_VAL;
        port_d_func_sel_0_r <= `PFSM_RST_VAL;
        port_d_func_sel_1_r <= `PFSM_RST_VAL;
        port_e_func_sel_0_r <= `PFSM_RST_VAL;
    end else if (clk_en) begin
        if (s_axi_awvalid && s_axi_awready) begin
            wr_addr_r <= s_axi_awaddr;
            wr_addr_ok_r <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wr_data_r <= s_axi_wdata[7:0];
            wr_strb0_r <= s_axi_wstrb[0];
            wr_data_ok_r <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (wr_go) begin
            wr_addr_ok_r <= 1'b0;
            wr_data_ok_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `PFSM_RESP_OKAY : `PFSM_RESP_SLVERR;
            // only byte lane 0 holds register bits
            if (wr_hit && wr_strb0_r) begin
                if (wr_addr_r == `PFSM_OFF_PA0) begin
                    port_a_func_sel_0_r <= wr_data_r;
                end else if (wr_addr_r == `PFSM_OFF_PA1) begin
                    port_a_func_sel_1_r <= wr_data_r & pa1_mask; // [RULE8]
                end else if (wr_addr_r == `PFSM_OFF_PB0) begin
                    port_b_func_sel_0_r <= wr_data_r;
                end else if (wr_addr_r == `PFSM_OFF_PB1) begin
                    port_b_func_sel_1_r <= wr_data_r;
                end else if (wr_addr_r == `PFSM_OFF_PC0) begin
                    port_c_func_sel_0_r <= wr_data_r;
                end else if (wr_addr_r == `PFSM_OFF_PC1) begin
                    port_c_func_sel_1_r <= wr_data_r & pc1_mask; // [RULE16]
                end else if (wr_addr_r == `PFSM_OFF_PD0) begin
                    port_d_func_sel_0_r <= wr_data_r & pd_mask; // [RULE17]
                end else if (wr_addr_r == `PFSM_OFF_PD1) begin
                    port_d_func_sel_1_r <= wr_data_r & pd_mask; // [RULE18]
                end else begin
                    port_e_func_sel_0_r <= wr_data_r & pe0_mask; // [RULE21]
                end
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_val};
            s_axi_rresp <= rd_hit ? `PFSM_RESP_OKAY : `PFSM_RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// function decode, combinational from the stored fields

reg [31:0] fa;
reg [31:0] fb;
reg [31:0] fc;
reg [31:0] fd;
reg [15:0] fe;
reg [5:0] tk3;
reg [5:0] tk2;
reg [5:0] tk1;
integer i, j;

always @* begin
    fa = 32'h00000000;
    fb = 32'h00000000;
    fc = 32'h00000000;
    fd = 32'h00000000;
    fe = 16'h0000;
    tk3 = 6'h00;
    tk2 = 6'h00;
    tk1 = 6'h00;
    // port a
    case (port_a_func_sel_0_r[7:6])
        `PFSM_SEL_ALT1: fa[15:12] = `PFSM_FN_SLAVE_SEL; // [RULE1]
        `PFSM_SEL_ALT2: fa[15:12] = `PFSM_FN_XTAL; // [RULE1]
        default: fa[15:12] = `PFSM_FN_GPIO;
    endcase
    if (port_a_func_sel_0_r[5:4] == `PFSM_SEL_ALT1) begin
        fa[11:8] = `PFSM_FN_SLAVE_SEL; // [RULE2]
    end
    if (port_a_func_sel_0_r[3:2] == `PFSM_SEL_ALT1) begin
        fa[7:4] = `PFSM_FN_TMR_OUT; // [RULE3]
    end
    if (port_a_func_sel_0_r[1:0] == `PFSM_SEL_ALT1) begin
        fa[3:0] = `PFSM_FN_SER_OUT; // [RULE4]
    end
    if (is_v1 && port_a_func_sel_1_r[7:6] == `PFSM_SEL_ALT1) begin
        fa[31:28] = `PFSM_FN_TMR_OUT; // [RULE5]
    end
    if (port_a_func_sel_1_r[3:2] == `PFSM_SEL_ALT1) begin
        fa[23:20] = `PFSM_FN_TMR_OUT_INV; // [RULE6]
    end
    case (port_a_func_sel_1_r[1:0])
        `PFSM_SEL_ALT1: fa[19:16] = `PFSM_FN_SER_OUT; // [RULE7]
        `PFSM_SEL_ALT2: fa[19:16] = `PFSM_FN_XTAL; // [RULE7]
        default: fa[19:16] = `PFSM_FN_GPIO;
    endcase
    // port b, low four pins: codes map to fixed functions
    case (port_b_func_sel_0_r[7:6])
        `PFSM_SEL_ALT1: fb[15:12] = `PFSM_FN_UART; // [RULE9]
        `PFSM_SEL_ALT3: fb[15:12] = `PFSM_FN_ANALOG; // [RULE9]
        default: fb[15:12] = `PFSM_FN_GPIO;
    endcase
    case (port_b_func_sel_0_r[5:4])
        `PFSM_SEL_ALT1: fb[11:8] = `PFSM_FN_UART; // [RULE10]
        `PFSM_SEL_ALT2: fb[11:8] = `PFSM_FN_TMR_OUT; // [RULE10]
        `PFSM_SEL_ALT3: fb[11:8] = `PFSM_FN_ANALOG; // [RULE10]
        default: fb[11:8] = `PFSM_FN_GPIO;
    endcase
    case (port_b_func_sel_0_r[3:2])
        `PFSM_SEL_ALT1: fb[7:4] = `PFSM_FN_SER_CLK; // [RULE11]
        `PFSM_SEL_ALT3: fb[7:4] = `PFSM_FN_ANALOG; // [RULE11]
        default: fb[7:4] = `PFSM_FN_GPIO;
    endcase
    case (port_b_func_sel_0_r[1:0])
        `PFSM_SEL_ALT1: fb[3:0] = `PFSM_FN_SER_IN; // [RULE12]
        `PFSM_SEL_ALT2: fb[3:0] = `PFSM_FN_VREF; // [RULE12]
        `PFSM_SEL_ALT3: fb[3:0] = `PFSM_FN_ANALOG; // [RULE12]
        default: fb[3:0] = `PFSM_FN_GPIO;
    endcase
    // port b, high four pins: 10 touch, 11 analog
    for (i = 0; i < 4; i = i + 1) begin
        case (port_b_func_sel_1_r[2*i+:2])
            `PFSM_SEL_ALT2: fb[16+4*i+:4] = `PFSM_FN_TOUCH; // [RULE13] [RULE14] [RULE15]
            `PFSM_SEL_ALT3: fb[16+4*i+:4] = `PFSM_FN_ANALOG; // [RULE13] [RULE14] [RULE15]
            default: fb[16+4*i+:4] = `PFSM_FN_GPIO;
        endcase
    end
    if (port_b_func_sel_1_r[1:0] == `PFSM_SEL_ALT1) begin
        fb[19:16] = `PFSM_FN_TMR_OUT_INV; // [RULE15]
    end
    // ports c and d: 10 touch, the rest io; masks keep v1 port c pins 4-7 and port d fields zero
    for (i = 0; i < 4; i = i + 1) begin
        if (port_c_func_sel_0_r[2*i+:2] == `PFSM_SEL_ALT2) begin
            fc[4*i+:4] = `PFSM_FN_TOUCH; // [RULE16]
        end
        if (port_c_func_sel_1_r[2*i+:2] == `PFSM_SEL_ALT2) begin
            fc[16+4*i+:4] = `PFSM_FN_TOUCH; // [RULE16]
        end
        if (port_d_func_sel_0_r[2*i+:2] == `PFSM_SEL_ALT2) begin
            fd[4*i+:4] = `PFSM_FN_TOUCH; // [RULE17]
        end
        if (port_d_func_sel_1_r[2*i+:2] == `PFSM_SEL_ALT2) begin
            fd[16+4*i+:4] = `PFSM_FN_TOUCH; // [RULE18]
        end
    end
    // port e: touch key number depends on variant, none on v2
    case (port_e_func_sel_0_r[7:6])
        `PFSM_SEL_ALT1: fe[15:12] = `PFSM_FN_TMR_OUT_INV; // [RULE19]
        `PFSM_SEL_ALT2: begin
            if (!is_v2) begin
                fe[15:12] = `PFSM_FN_TOUCH; // [RULE19]
                tk3 = is_v1 ? 6'h0C : 6'h18;
            end
        end
        default: fe[15:12] = `PFSM_FN_GPIO;
    endcase
    case (port_e_func_sel_0_r[5:4])
        `PFSM_SEL_ALT1: fe[11:8] = `PFSM_FN_TMR_OUT; // [RULE20]
        `PFSM_SEL_ALT2: begin
            if (!is_v2) begin
                fe[11:8] = `PFSM_FN_TOUCH; // [RULE20]
                tk2 = is_v1 ? 6'h0B : 6'h17;
            end
        end
        default: fe[11:8] = `PFSM_FN_GPIO;
    endcase
    if (port_e_func_sel_0_r[3:2] == `PFSM_SEL_ALT2) begin
        fe[7:4] = `PFSM_FN_TOUCH; // [RULE21]
        tk1 = is_v1 ? 6'h0A : 6'h16;
    end
end

// status: pins on touch keys, for software sanity checks
always @* begin
    touch_count = 6'h00;
    for (j = 0; j < 8; j = j + 1) begin
        touch_count = touch_count + {5'h00, fb[4*j+:4] == `PFSM_FN_TOUCH};
        touch_count = touch_count + {5'h00, fc[4*j+:4] == `PFSM_FN_TOUCH};
        touch_count = touch_count + {5'h00, fd[4*j+:4] == `PFSM_FN_TOUCH};
    end
    for (j = 0; j < 4; j = j + 1) begin
        touch_count = touch_count + {5'h00, fe[4*j+:4] == `PFSM_FN_TOUCH};
    end
end

////////////////////////////////////////////////////////////////////////////////
// registered outputs; a write is visible one cycle after the store

always @(posedge aclk) begin
    if (!aresetn) begin
        port_a_func_r <= 32'h00000000;
        port_b_func_r <= 32'h00000000;
        port_c_func_r <= 32'h00000000;
        port_d_func_r <= 32'h00000000;
        port_e_func_r <= 16'h0000;
        compact_timer1_clock_in_en_r <= is_v1;
        periodic_timer_capture_in_en_r <= 2'h3;
        periodic_timer_clock_in_en_r <= 1'b1;
        standard_timer_clock_in_en_r <= 1'b1;
        external_interrupt_one_en_r <= 1'b1;
        standard_timer_capture_in_en_r <= 2'h3;
        porte_bit3_touch_r <= 6'h00;
        porte_bit2_touch_r <= 6'h00;
        porte_bit1_touch_r <= 6'h00;
    end else if (clk_en) begin
        port_a_func_r <= fa; // [RULE22]
        port_b_func_r <= fb;
        port_c_func_r <= fc;
        port_d_func_r <= fd;
        port_e_func_r <= fe;
        compact_timer1_clock_in_en_r <= is_v1 && fa[11:8] == `PFSM_FN_GPIO; // [RULE2]
        periodic_timer_capture_in_en_r <= {port_b_func_sel_1_r[1:0] == `PFSM_SEL_GPIO,
            port_b_func_sel_0_r[5:4] == `PFSM_SEL_GPIO}; // [RULE10] [RULE15]
        periodic_timer_clock_in_en_r <= !port_b_func_sel_1_r[5]; // [RULE14]
        standard_timer_clock_in_en_r <= !port_b_func_sel_1_r[3]; // [RULE14]
        external_interrupt_one_en_r <= !port_b_func_sel_1_r[7]; // [RULE13]
        standard_timer_capture_in_en_r <= {fe[15:12] == `PFSM_FN_GPIO,
            fe[11:8] == `PFSM_FN_GPIO}; // [RULE19] [RULE20]
        porte_bit3_touch_r <= tk3;
        porte_bit2_touch_r <= tk2;
        porte_bit1_touch_r <= tk1;
    end
end

endmodule
`default_nettype wire
